//--- logic/irs_pkg.sv
// package for the interrupt routing and reference sync block
// assumes byte registers on a 32-bit avalon-mm slave, one word per register
package irs_pkg;
	// register indices (byte address is four times the index)
	localparam logic [9:0] IRS_IDX_EVT_STATUS   = 10'h027;
	localparam logic [9:0] IRS_IDX_EVT_ENABLE   = 10'h01F;
	localparam logic [9:0] IRS_IDX_AMP_ROUTE    = 10'h02A;
	localparam logic [9:0] IRS_IDX_LOCK_ROUTE   = 10'h02B;
	localparam logic [9:0] IRS_IDX_SUMMARY      = 10'h02C;
	localparam logic [9:0] IRS_IDX_IGNORE_COUNT = 10'h036;
	localparam logic [9:0] IRS_IDX_JITTER_TOL   = 10'h039;
	localparam logic [9:0] IRS_IDX_SYNC_MODE    = 10'h03A;
	localparam logic [9:0] IRS_IDX_AMP_STATUS   = 10'h026;
	localparam logic [9:0] IRS_IDX_AMP_ENABLE   = 10'h01E;
	localparam logic [9:0] IRS_IDX_REF_STATUS   = 10'h024;
	localparam logic [9:0] IRS_IDX_REF_ENABLE   = 10'h01C;
	// bit positions in the lock, amp and ref event registers and in the summary and mode registers
	localparam int IRS_BIT_DLL_LOST   = 5;
	localparam int IRS_BIT_DLL_LOCK   = 4;
	localparam int IRS_BIT_PLL_LOST   = 1;
	localparam int IRS_BIT_PLL_LOCK   = 0;
	localparam int IRS_BIT_AMP_ERR    = 0;
	localparam int IRS_BIT_REF_JITTER = 4;
	localparam int IRS_BIT_SUMMARY    = 0;
	localparam int IRS_BIT_ONESHOT    = 1;
	localparam int IRS_BIT_ROT_DONE   = 4;
	// writable masks
	localparam logic [7:0] IRS_LOCK_MASK  = 8'h33;
	localparam logic [7:0] IRS_ONE_MASK   = 8'h01;
	localparam logic [7:0] IRS_TOL_MASK   = 8'h7F;
	localparam logic [7:0] IRS_MODE_MASK  = 8'h02;
	localparam logic [7:0] IRS_REFST_MASK = 8'h10;
	// reset values
	localparam logic [7:0] IRS_RST_ZERO = 8'h00;
	localparam logic       IRS_RST_ROT_DONE = 1'b1;
	// rotation takes this many clocks after the trigger edge
	localparam int IRS_ROT_CYCLES = 8;
	typedef enum logic [1:0] {IRS_SYNC_MONITOR, IRS_SYNC_ARMED, IRS_SYNC_ROTATE} irs_sync_state_t;
endpackage

//--- logic/irs_reg_if.sv
// bundle from the bus slave into the event status bank
// assumes both ends share clk_in
`timescale 1ns/100ps
interface irs_reg_if;
	logic [7:0] wr_clr;
	logic       clr_all;
	logic [7:0] enable;
	logic [7:0] live;
	logic [7:0] status;
	modport ctrl (output wr_clr, output clr_all, output enable, output live, input status);
	modport bank (input wr_clr, input clr_all, input enable, input live, output status);
endinterface

//--- logic/irs_evt_bank.sv
// one 8-bit bank of event status flags, live or latched per enable
// assumes live conditions already synchronised to clk_in
`timescale 1ns/100ps
module irs_evt_bank
	import irs_pkg::*;
#(
	parameter logic [7:0] VALID = 8'hFF
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	irs_reg_if.bank   port
);
	typedef struct packed {
		logic [7:0] status;
	} irs_bank_t;
	irs_bank_t s_q;
	irs_bank_t s_d;

	always_comb begin
		s_d = s_q;
		for (int i = 0; i < 8; i++) begin
			if (!VALID[i]) begin
				s_d.status[i] = 1'b0;
			end else if (!port.enable[i]) begin
				s_d.status[i] = port.live[i];
			end else if (port.live[i]) begin
				s_d.status[i] = 1'b1; // set wins over clear
			end else if (port.wr_clr[i] || port.clr_all) begin
				s_d.status[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign port.status = s_q.status;
endmodule

//--- logic/irs_top.sv
// interrupt pin routing, summary interrupt and reference sync control
// assumes event pins and ref edge come from outside and are synchronised here
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
// How it works
// - lock route bit 5 picks the pin for the delay loop unlock event.
// - lock route bit 4 picks the pin for the delay loop lock event.
// - lock route bit 1 picks the pin for the clock loop unlock event.
// - lock route bit 0 picks the pin for the clock loop lock event.
// - route 0 means pin a, 1 means pin b, all routes reset to 0.
// - amp route bit 0 picks the pin for the second amplifier error event.
// - the summary bit is the OR of every event status bit.
// - writing one to the summary bit clears every latched status bit.
// - in one-shot mode the given number of rising ref edges is skipped first.
// - jitter flag rises when the ref edge period moves beyond the tolerance.
// - bit 4 of the mode register is a read-only rotation done flag, reset 1.
// - one-shot set syncs once on the first edge after the ignored ones then returns to monitor.
// - in monitor mode an edge outside the window sets the jitter status.
// - disabled events show live state, enabled ones latch and pull the pin low.
module irs_top
	import irs_pkg::*;
#(
	parameter int PERIOD_W = 16
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// avalon-mm slave
	input  wire logic [11:0] avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// live event conditions from the clock blocks
	input  wire logic        dll_lost_in,
	input  wire logic        dll_lock_in,
	input  wire logic        pll_lost_in,
	input  wire logic        pll_lock_in,
	input  wire logic        amp_error_b_in,
	input  wire logic        ref_edge_in,
	// interrupt pins, active low
	output logic             interrupt_pin_a_n_out,
	output logic             interrupt_pin_b_n_out,
	// sync control and interrupt request
	output logic             rotate_pulse_out,
	output logic             irq_out
);
	// elaboration check: the counter must outgrow the 7-bit tolerance
	if (PERIOD_W < 8 || PERIOD_W > 30) begin
		$error("PERIOD_W out of range");
	end

	typedef struct packed {
		logic [5:0]          sync1;
		logic [5:0]          sync2;
		logic                ref_prev;
		logic [7:0]          lock_route;
		logic                amp_error_b_route;
		logic [7:0]          lock_enable;
		logic                amp_error_b_enable;
		logic                ref_jitter_enable;
		logic                ref_jitter_route;
		logic [7:0]          ref_edge_ignore_count;
		logic [6:0]          ref_jitter_tolerance;
		logic                single_sync_select;
		logic                rot_done;
		irs_sync_state_t     st;
		logic [7:0]          skip_cnt;
		logic [3:0]          rot_cnt;
		logic [PERIOD_W-1:0] per_cnt;
		logic [PERIOD_W-1:0] per_last;
		logic                per_valid;
		logic                jit_live;
		logic                rotate;
		logic                ack;
		logic [31:0]         rdata;
		logic                pin_a_n;
		logic                pin_b_n;
		logic                irq;
	} irs_state_t;
	irs_state_t s_q;
	irs_state_t s_d;

	irs_reg_if lock_bus ();
	irs_reg_if amp_bus ();
	irs_reg_if ref_bus ();

	irs_evt_bank #(.VALID(IRS_LOCK_MASK)) u_lock (.clk_in(clk_in), .rst_in(rst_in), .port(lock_bus.bank));
	irs_evt_bank #(.VALID(IRS_ONE_MASK)) u_amp (.clk_in(clk_in), .rst_in(rst_in), .port(amp_bus.bank));
	irs_evt_bank #(.VALID(IRS_REFST_MASK)) u_ref (.clk_in(clk_in), .rst_in(rst_in), .port(ref_bus.bank));

	logic [9:0]          idx;
	logic                wr;
	logic [7:0]          wd;
	logic                summary;
	logic                edge_seen;
	logic [PERIOD_W-1:0] diff;
	logic                to_a;
	logic                to_b;
	logic [7:0]          rd8;

	assign idx = avs_address_in[11:2];
	// only a byte lane 0 write counts; registers are 8 bits wide
	// applied on the ack edge, the one where the master sees waitrequest low
	assign wr = avs_write_in && s_q.ack && avs_byteenable_in[0];
	assign wd = avs_writedata_in[7:0];
	assign summary = |lock_bus.status || |amp_bus.status || |ref_bus.status;
	assign edge_seen = s_q.sync2[5] && !s_q.ref_prev;

	always_comb begin
		lock_bus.live = {2'b00, s_q.sync2[0], s_q.sync2[1], 2'b00, s_q.sync2[2], s_q.sync2[3]};
		lock_bus.enable = s_q.lock_enable;
		amp_bus.live = {7'h00, s_q.sync2[4]};
		amp_bus.enable = {7'h00, s_q.amp_error_b_enable};
		ref_bus.live = 8'h00;
		ref_bus.live[IRS_BIT_REF_JITTER] = s_q.jit_live;
		ref_bus.enable = 8'h00;
		ref_bus.enable[IRS_BIT_REF_JITTER] = s_q.ref_jitter_enable;
		lock_bus.wr_clr = (wr && idx == IRS_IDX_EVT_STATUS) ? wd : 8'h00;
		amp_bus.wr_clr = (wr && idx == IRS_IDX_AMP_STATUS) ? wd : 8'h00;
		ref_bus.wr_clr = (wr && idx == IRS_IDX_REF_STATUS) ? wd : 8'h00;
		lock_bus.clr_all = wr && idx == IRS_IDX_SUMMARY && wd[IRS_BIT_SUMMARY];
		amp_bus.clr_all = lock_bus.clr_all;
		ref_bus.clr_all = lock_bus.clr_all;
	end

	always_comb begin
		diff = '0;
		to_a = 1'b0;
		to_b = 1'b0;
		rd8 = 8'h00;
		s_d = s_q;
		s_d.sync1 = {ref_edge_in, amp_error_b_in, pll_lock_in, pll_lost_in, dll_lock_in, dll_lost_in};
		s_d.sync2 = s_q.sync1;
		s_d.ref_prev = s_q.sync2[5];
		s_d.rotate = 1'b0;

		// bus slave: one wait cycle then ack
		s_d.ack = (avs_read_in || avs_write_in) && !s_q.ack;
		case (idx)
			IRS_IDX_LOCK_ROUTE:   rd8 = s_q.lock_route;
			IRS_IDX_AMP_ROUTE:    rd8 = {7'h00, s_q.amp_error_b_route};
			IRS_IDX_EVT_ENABLE:   rd8 = s_q.lock_enable;
			IRS_IDX_AMP_ENABLE:   rd8 = {7'h00, s_q.amp_error_b_enable};
			IRS_IDX_REF_ENABLE:   rd8 = {3'h0, s_q.ref_jitter_enable, 4'h0};
			IRS_IDX_EVT_STATUS:   rd8 = lock_bus.status;
			IRS_IDX_AMP_STATUS:   rd8 = amp_bus.status;
			IRS_IDX_REF_STATUS:   rd8 = ref_bus.status;
			IRS_IDX_SUMMARY:      rd8 = {7'h00, summary};
			IRS_IDX_IGNORE_COUNT: rd8 = s_q.ref_edge_ignore_count;
			IRS_IDX_JITTER_TOL:   rd8 = {1'b0, s_q.ref_jitter_tolerance};
			IRS_IDX_SYNC_MODE:    rd8 = {3'h0, s_q.rot_done, 2'b00, s_q.single_sync_select, 1'b0};
			default:              rd8 = 8'h00;
		endcase
		s_d.rdata = {24'h000000, rd8};
		if (wr) begin
			case (idx)
				IRS_IDX_LOCK_ROUTE:   s_d.lock_route = wd & IRS_LOCK_MASK;
				IRS_IDX_AMP_ROUTE:    s_d.amp_error_b_route = wd[IRS_BIT_AMP_ERR];
				IRS_IDX_EVT_ENABLE:   s_d.lock_enable = wd & IRS_LOCK_MASK;
				IRS_IDX_AMP_ENABLE:   s_d.amp_error_b_enable = wd[IRS_BIT_AMP_ERR];
				IRS_IDX_REF_ENABLE:   s_d.ref_jitter_enable = wd[IRS_BIT_REF_JITTER];
				IRS_IDX_IGNORE_COUNT: s_d.ref_edge_ignore_count = wd;
				IRS_IDX_JITTER_TOL:   s_d.ref_jitter_tolerance = wd[6:0];
				IRS_IDX_SYNC_MODE:    s_d.single_sync_select = wd[IRS_BIT_ONESHOT];
				default: begin
				end
			endcase
		end

		// reference period monitor
		s_d.jit_live = 1'b0;
		if (!(&s_q.per_cnt)) begin
			s_d.per_cnt = s_q.per_cnt + 1'b1;
		end
		if (edge_seen) begin
			s_d.per_cnt = '0;
			s_d.per_last = s_q.per_cnt;
			s_d.per_valid = 1'b1;
			diff = (s_q.per_cnt > s_q.per_last) ? s_q.per_cnt - s_q.per_last : s_q.per_last - s_q.per_cnt;
			// only judged in monitor mode, first edge has nothing to compare
			if (s_q.st == IRS_SYNC_MONITOR && s_q.per_valid &&
			    diff > {{(PERIOD_W-7){1'b0}}, s_q.ref_jitter_tolerance}) begin
				s_d.jit_live = 1'b1;
			end
		end

		// sync sequencer
		case (s_q.st)
			IRS_SYNC_MONITOR: begin
				if (s_q.single_sync_select) begin
					s_d.st = IRS_SYNC_ARMED;
					s_d.skip_cnt = s_q.ref_edge_ignore_count;
					s_d.rot_done = 1'b0;
				end
			end
			IRS_SYNC_ARMED: begin
				if (edge_seen) begin
					if (s_q.skip_cnt != 8'h00) begin
						s_d.skip_cnt = s_q.skip_cnt - 8'h01;
					end else begin
						s_d.st = IRS_SYNC_ROTATE;
						s_d.rotate = 1'b1;
						s_d.rot_cnt = 4'(IRS_ROT_CYCLES - 1);
					end
				end
			end
			IRS_SYNC_ROTATE: begin
				if (s_q.rot_cnt != 4'h0) begin
					s_d.rot_cnt = s_q.rot_cnt - 4'h1;
				end else begin
					s_d.rot_done = 1'b1;
					s_d.single_sync_select = 1'b0;
					s_d.st = IRS_SYNC_MONITOR;
				end
			end
			default: s_d.st = IRS_SYNC_MONITOR;
		endcase

		// pin routing, latched enabled events only
		for (int i = 0; i < 8; i++) begin
			if (s_q.lock_enable[i] && lock_bus.status[i]) begin
				if (s_q.lock_route[i]) to_b = 1'b1;
				else to_a = 1'b1;
			end
		end
		if (s_q.amp_error_b_enable && amp_bus.status[IRS_BIT_AMP_ERR]) begin
			if (s_q.amp_error_b_route) to_b = 1'b1;
			else to_a = 1'b1;
		end
		if (s_q.ref_jitter_enable && ref_bus.status[IRS_BIT_REF_JITTER]) begin
			if (s_q.ref_jitter_route) to_b = 1'b1;
			else to_a = 1'b1;
		end
		s_d.pin_a_n = !to_a;
		s_d.pin_b_n = !to_b;
		s_d.irq = to_a || to_b;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.rot_done <= IRS_RST_ROT_DONE;
			s_q.pin_a_n <= 1'b1;
			s_q.pin_b_n <= 1'b1;
			s_q.st <= IRS_SYNC_MONITOR;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata_out = s_q.rdata;
	assign avs_waitrequest_out = !s_q.ack;
	assign interrupt_pin_a_n_out = s_q.pin_a_n;
	assign interrupt_pin_b_n_out = s_q.pin_b_n;
	assign rotate_pulse_out = s_q.rotate;
	assign irq_out = s_q.irq;
endmodule

//--- verif/irs_top_sva.sv
// checks on irs_top ports: read fields, rotation pulse, pins
// assumes it is bound to irs_top
`timescale 1ns/100ps
module irs_top_sva
	import irs_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic [11:0] avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_waitrequest_out,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        ref_edge_in,
	input wire logic        interrupt_pin_a_n_out,
	input wire logic        interrupt_pin_b_n_out,
	input wire logic        rotate_pulse_out,
	input wire logic        irq_out
);
	logic       ack;
	logic [9:0] idx;
	logic       ref_q;
	logic [3:0] rot_age_q;
	logic [3:0] ref_age_q;
	assign ack = avs_read_in && !avs_waitrequest_out;
	assign idx = avs_address_in[11:2];
	// saturating ages, 15 means long ago
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ref_q <= 1'b0;
			rot_age_q <= 4'hF;
			ref_age_q <= 4'hF;
		end else begin
			ref_q <= ref_edge_in;
			rot_age_q <= rotate_pulse_out ? 4'h0 : rot_age_q + {3'h0, rot_age_q != 4'hF};
			ref_age_q <= (ref_edge_in && !ref_q) ? 4'h0 : ref_age_q + {3'h0, ref_age_q != 4'hF};
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_upper; ack |-> avs_readdata_out[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("read data upper bits set");
	property p_route; ack && idx == IRS_IDX_LOCK_ROUTE |-> (avs_readdata_out[7:0] & 8'hCC) == 8'h00; endproperty
	a_route: assert property (p_route) else $error("route reserved bits set");
	property p_tol; ack && idx == IRS_IDX_JITTER_TOL |-> !avs_readdata_out[7]; endproperty
	a_tol: assert property (p_tol) else $error("tolerance bit 7 set");
	property p_mode; ack && idx == IRS_IDX_SYNC_MODE |-> (avs_readdata_out[7:0] & 8'hED) == 8'h00; endproperty
	a_mode: assert property (p_mode) else $error("mode reserved bits set");
	property p_busy; ack && idx == IRS_IDX_SYNC_MODE && rot_age_q < 4'h6 |-> !avs_readdata_out[4]; endproperty
	a_busy: assert property (p_busy) else $error("done flag high during rotation");
	property p_once; rotate_pulse_out |=> !rotate_pulse_out [*8]; endproperty
	a_once: assert property (p_once) else $error("second rotation too soon");
	property p_cause; rotate_pulse_out |-> ref_age_q <= 4'h6; endproperty
	a_cause: assert property (p_cause) else $error("rotation without ref edge");
	property p_irq; !interrupt_pin_a_n_out || !interrupt_pin_b_n_out |-> ##[0:1] irq_out; endproperty
	a_irq: assert property (p_irq) else $error("irq low while pin pulled");
	property p_rst; $fell(rst_in) |-> interrupt_pin_a_n_out && interrupt_pin_b_n_out; endproperty
	a_rst: assert property (p_rst) else $error("pin low after reset");
endmodule

//--- verif/irs_host_model.sv
// host side: samples both active-low interrupt pins
// assumes pins are registered on clk_in by the device
`timescale 1ns/100ps
module irs_host_model (
	input  wire logic  clk_in,
	input  wire logic  pin_a_n_in,
	input  wire logic  pin_b_n_in,
	output logic [1:0] seen_out
);
	// low means pending; host clears by writing one
	always_ff @(posedge clk_in) seen_out <= {!pin_b_n_in, !pin_a_n_in};
endmodule

//--- verif/irs_top_test.sv
// testbench: avalon master, event and ref drivers, read scoreboard
// assumes irs_top, irs_host_model and irs_top_sva compiled first
`timescale 1ns/100ps
module irs_top_test import irs_pkg::*; ;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [11:0] avs_address_in = 12'h000;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0]  avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic [4:0]  ev = 5'h00;
	logic        ref_edge_in = 1'b0;
	logic        pin_a_n, pin_b_n, rotate_pulse_out, irq_out;
	logic [1:0]  seen;
	logic [31:0] exp_q[$];
	logic [31:0] rnd = 32'd87859;
	logic [7:0]  r, n;
	logic [9:0]  si;
	int          t, mismatches = 0, samples_checked = 0, pulses = 0;
	int          bp[5] = '{5, 4, 1, 0, 0};
	logic [9:0]  ri[7] = '{IRS_IDX_LOCK_ROUTE, IRS_IDX_SUMMARY, IRS_IDX_IGNORE_COUNT, IRS_IDX_JITTER_TOL,
		IRS_IDX_SYNC_MODE, IRS_IDX_AMP_ROUTE, 10'h3FF};
	logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
	irs_top irs_top_inst (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.dll_lost_in(ev[0]), .dll_lock_in(ev[1]), .pll_lost_in(ev[2]), .pll_lock_in(ev[3]),
		.amp_error_b_in(ev[4]), .ref_edge_in(ref_edge_in), .interrupt_pin_a_n_out(pin_a_n),
		.interrupt_pin_b_n_out(pin_b_n), .rotate_pulse_out(rotate_pulse_out), .irq_out(irq_out));
	irs_host_model irs_host_model_inst (.clk_in(clk_in), .pin_a_n_in(pin_a_n), .pin_b_n_in(pin_b_n), .seen_out(seen));
	always #2.5 clk_in = ~clk_in;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one request, held until waitrequest is sampled low
	task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d);
		int c = 0;
		@(posedge clk_in);
		avs_address_in <= {i, 2'b00};
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_writedata_in <= {24'h0, d};
		do begin
			@(posedge clk_in);
			c++;
		end while (avs_waitrequest_out !== 1'b0 && c < 20);
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (c >= 20) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		xfer(1'b0, i, 8'h00);
	endtask
	// pins {b, a} active high as the host sees them; six clocks cover sync and latch
	task automatic pins(input logic [1:0] e);
		repeat (6) @(posedge clk_in);
		check("pins", {29'h0, irq_out, seen}, {29'h0, |e, e});
	endtask
	task automatic ref_rise(input int p);
		@(posedge clk_in);
		ref_edge_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		ref_edge_in <= 1'b0;
		repeat (p - 3) @(posedge clk_in);
	endtask
	always @(posedge clk_in) begin
		if (avs_read_in && avs_waitrequest_out === 1'b0) begin
			check("readdata", exp_q.pop_front(), avs_readdata_out);
		end
		if (rotate_pulse_out === 1'b1) begin
			pulses <= pulses + 1;
		end
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		foreach (ri[k]) begin
			rd(ri[k], rv[k]);
		end
		xfer(1'b1, 10'h3FF, 8'hFF);
		rd(10'h3FF, 8'h00);
		xfer(1'b1, IRS_IDX_SYNC_MODE, 8'hED);
		rd(IRS_IDX_SYNC_MODE, 8'h10);
		xfer(1'b1, IRS_IDX_EVT_ENABLE, 8'h33);
		xfer(1'b1, IRS_IDX_AMP_ENABLE, 8'h01);
		rnd = lfsr(rnd);
		for (int p = 0; p < 2; p++) begin
			r = rnd[7:0] ^ {8{p[0]}};
			xfer(1'b1, IRS_IDX_LOCK_ROUTE, r);
			xfer(1'b1, IRS_IDX_AMP_ROUTE, r);
			rd(IRS_IDX_LOCK_ROUTE, r & 8'h33);
			rd(IRS_IDX_AMP_ROUTE, r & 8'h01);
			for (int k = 0; k < 5; k++) begin
				si = k < 4 ? IRS_IDX_EVT_STATUS : IRS_IDX_AMP_STATUS;
				ev[k] <= 1'b1;
				pins(r[bp[k]] ? 2'b10 : 2'b01);
				ev[k] <= 1'b0;
				rd(si, 8'h01 << bp[k]);
				xfer(1'b1, si, 8'h01 << bp[k]);
				pins(2'b00);
			end
		end
		// disabled event follows the live level and never pulls a pin
		xfer(1'b1, IRS_IDX_EVT_ENABLE, 8'h00);
		ev[0] <= 1'b1;
		pins(2'b00);
		rd(IRS_IDX_EVT_STATUS, 8'h20);
		rd(IRS_IDX_SUMMARY, 8'h01);
		ev[0] <= 1'b0;
		pins(2'b00);
		rd(IRS_IDX_EVT_STATUS, 8'h00);
		xfer(1'b1, IRS_IDX_EVT_ENABLE, 8'h33);
		ev <= 5'h0A;
		pins({r[4] | r[0], !(r[4] & r[0])});
		ev <= 5'h00;
		rd(IRS_IDX_SUMMARY, 8'h01);
		xfer(1'b1, IRS_IDX_SUMMARY, 8'h01);
		pins(2'b00);
		rd(IRS_IDX_EVT_STATUS, 8'h00);
		rd(IRS_IDX_SUMMARY, 8'h00);
		rnd = lfsr(rnd);
		n = {6'h00, rnd[1:0]};
		xfer(1'b1, IRS_IDX_IGNORE_COUNT, n);
		rd(IRS_IDX_IGNORE_COUNT, n);
		// a write without byte lane 0 must leave the count alone
		avs_byteenable_in <= 4'hE;
		xfer(1'b1, IRS_IDX_IGNORE_COUNT, 8'hA5);
		avs_byteenable_in <= 4'hF;
		rd(IRS_IDX_IGNORE_COUNT, n);
		xfer(1'b1, IRS_IDX_SYNC_MODE, 8'h02);
		for (int i = 0; i < n; i++) begin
			ref_rise(20);
		end
		check("rotations", 32'd0, pulses);
		ref_edge_in <= 1'b1;
		for (int i = 0; i < 12 && pulses == 0; i++) begin
			@(posedge clk_in);
		end
		if (pulses == 0) begin
			mismatches++;
			tally_and_finish();
		end
		rd(IRS_IDX_SYNC_MODE, 8'h02);
		ref_edge_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		rd(IRS_IDX_SYNC_MODE, 8'h10);
		ref_rise(20);
		ref_rise(20);
		check("rotations", 32'd1, pulses);
		rnd = lfsr(rnd);
		t = rnd[6:0];
		xfer(1'b1, IRS_IDX_JITTER_TOL, rnd[7:0]);
		rd(IRS_IDX_JITTER_TOL, rnd[7:0] & 8'h7F);
		xfer(1'b1, IRS_IDX_REF_ENABLE, 8'h10);
		// periods drift by t, then by t + 1; the bus works between edges
		fork
			begin
				repeat (3) ref_rise(20);
				ref_rise(20 + t);
				ref_rise(21 + 2 * t);
				ref_rise(10);
			end
			begin
				repeat (74) @(posedge clk_in);
				xfer(1'b1, IRS_IDX_REF_STATUS, 8'h10);
				repeat (15 + t) @(posedge clk_in);
				rd(IRS_IDX_REF_STATUS, 8'h00);
			end
		join
		rd(IRS_IDX_REF_STATUS, 8'h10);
		pins(2'b01);
		xfer(1'b1, IRS_IDX_SUMMARY, 8'h01);
		pins(2'b00);
		tally_and_finish();
	end
endmodule
bind irs_top irs_top_sva irs_top_sva_inst (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_waitrequest_out(avs_waitrequest_out), .avs_readdata_out(avs_readdata_out),
	.ref_edge_in(ref_edge_in), .interrupt_pin_a_n_out(interrupt_pin_a_n_out),
	.interrupt_pin_b_n_out(interrupt_pin_b_n_out), .rotate_pulse_out(rotate_pulse_out), .irq_out(irq_out));
